// file: tb/cvg_far_end.sv
`timescale 1ns/1ns
module cvg_far_end (
	// Oscillator run and result value.
	input  wire logic       rc_run_i,
	input  wire logic [9:0] value_i,
	// Lines into the block.
	output logic            rc_clk_o,
	output logic [9:0]      result_o
);
	initial rc_clk_o = 1'b0;
	// A 72 ns period never puts an edge on a rising system clock edge, so the synchroniser sees no race.
	always #36 rc_clk_o = rc_run_i ? ~rc_clk_o : 1'b0;
	assign result_o = value_i;
endmodule

// file: tb/cvg_timing_guard_monitor.sv
`timescale 1ns/1ns
module cvg_timing_guard_monitor (
	// Clock, reset and bus.
	input wire        sys_clk_i,
	input wire        rst_b_i,
	input wire        psel_i,
	input wire        penable_i,
	input wire        pwrite_i,
	input wire [31:0] prdata_o,
	input wire        pready_o,
	input wire        pslverr_o,
	// Guard, capacitor and stage.
	input wire        guard_a_pin_o,
	input wire        guard_a_pin_oe_o,
	input wire        guard_b_pin_o,
	input wire        guard_b_pin_oe_o,
	input wire [7:0]  extra_cap_onehot_o,
	input wire [4:0]  extra_cap_pf_o,
	input wire [1:0]  stage_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	ready_after_setup_a: assert property (psel_i && !penable_i |=> pready_o) else $error("no ready");
	ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready held");
	error_with_ready_a: assert property (pslverr_o |-> pready_o) else $error("error alone");
	upper_zero_a: assert property (pready_o && !pwrite_i |-> prdata_o[31:10] == 22'h0) else $error("upper bits");
	cap_decode_a: assert property (extra_cap_pf_o[1:0] == 2'h0 && extra_cap_onehot_o ==
		(extra_cap_pf_o == 5'h00 ? 8'h00 : 8'h01 << extra_cap_pf_o[4:2])) else $error("cap decode");
	pre_level_a: assert property ((stage_o == 2'h1) [*3] ##0 (guard_a_pin_oe_o && guard_b_pin_oe_o)
		|-> guard_a_pin_o == guard_b_pin_o) else $error("pre level");
	acq_flip_a: assert property ((stage_o == 2'h2) [*3] ##0 (guard_a_pin_oe_o && guard_b_pin_oe_o)
		|-> guard_a_pin_o != guard_b_pin_o) else $error("acq flip");
	stage_order_a: assert property ($past(stage_o) == 2'h2 |-> stage_o != 2'h1) else $error("order");
endmodule
bind cvg_timing_guard cvg_timing_guard_monitor u_mon (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .guard_a_pin_o(guard_a_pin_o), .guard_a_pin_oe_o(guard_a_pin_oe_o),
	.guard_b_pin_o(guard_b_pin_o), .guard_b_pin_oe_o(guard_b_pin_oe_o),
	.extra_cap_onehot_o(extra_cap_onehot_o), .extra_cap_pf_o(extra_cap_pf_o), .stage_o(stage_o));

// file: tb/cvg_timing_guard_tb.sv
`timescale 1ns/1ns
`include "cvg_map.vh"
module cvg_timing_guard_tb;
	logic        clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, rc_run = 0;
	logic        pready, perr, rc_clk, ga, gao, gb, gbo, lerr;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r, d;
	logic [31:0] msk [4] = '{32'h7f, 32'h7f, 32'he0, 32'h07};
	logic [9:0]  val = 0, res;
	logic [7:0]  oh;
	logic [4:0]  pf;
	logic [1:0]  st;
	int          bad_count = 0, compares = 0, i, j, k, np, na, n1, n2;
	cvg_timing_guard DUT (.sys_clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
		.rc_clk_pin_i(rc_clk), .conv_result_i(res), .guard_a_pin_o(ga), .guard_a_pin_oe_o(gao),
		.guard_b_pin_o(gb), .guard_b_pin_oe_o(gbo), .extra_cap_onehot_o(oh), .extra_cap_pf_o(pf), .stage_o(st));
	cvg_far_end far (.rc_run_i(rc_run), .value_i(val), .rc_clk_o(rc_clk), .result_o(res));
	always #5 clk = ~clk;
	task end_of_test;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task timeout;
		bad_count++;
		end_of_test();
	endtask
	task chk(input logic [31:0] g, e);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task chk_dur(input int v, n, rc);
		compares++;
		if (n == 0 ? v != 0 : (v < (rc ? 7 * n - 8 : 4 * n - 3) || v > (rc ? 8 * n + 2 : 4 * n + 1))) begin
			bad_count++;
			$display("MISMATCH %0t got %h exp %h", $time, v, n);
		end
	endtask
	// The bus holds every request field until the edge that sees ready.
	task apb(input int a, input logic [31:0] wd, input int w);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		paddr <= a[11:0];
		pwr <= w[0];
		pwdata <= wd;
		@(posedge clk);
		pen <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		r = prdata;
		lerr = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (n == 16)
			timeout();
	endtask
	task run_conv;
		int t;
		bit seen;
		np = 0;
		na = 0;
		seen = 0;
		for (t = 0; t < 4000; t++) begin
			@(posedge clk);
			np += (st === 2'h1);
			na += (st === 2'h2);
			if (st !== 2'h0)
				seen = 1;
			else if (seen)
				break;
		end
		if (t == 4000)
			timeout();
	endtask
	function logic [31:0] fh(input logic [9:0] v, input logic rj);
		fh = rj ? {30'h0, v[9:8]} : {24'h0, v[9:2]};
	endfunction
	function logic [31:0] fl(input logic [9:0] v, input logic rj);
		fl = rj ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h00};
	endfunction
	initial begin
		d = $urandom(72058);
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		for (i = 0; i < 9; i++) begin
			apb(4 * i, 0, 0);
			chk(r, 0);
		end
		apb(12'h024, 32'hff, 1);
		chk(lerr, 1);
		for (i = 0; i < 4; i++) begin
			d = $urandom;
			apb(4 * i, d, 1);
			apb(4 * i, 0, 0);
			chk(r, d & msk[i]);
		end
		for (i = 0; i < 8; i++) begin
			apb(`CVG_OFF_CAP, 32'(i), 1);
			repeat (2) @(posedge clk);
			chk(pf, 32'(4 * i));
			chk(oh, i ? 32'(1 << i) : 0);
		end
		apb(`CVG_OFF_GRD, 32'he0, 1);
		repeat (2) @(posedge clk);
		chk({gao, gbo}, 0);
		apb(`CVG_OFF_CTRL, 32'h1, 1);
		repeat (2) @(posedge clk);
		chk({gao, gbo, ga, gb}, 4'hf);
		apb(`CVG_OFF_GRD, 32'h40, 1);
		repeat (2) @(posedge clk);
		chk({gao, gbo, ga}, 3'h4);
		for (k = 0; k < 4; k++) begin
			n1 = (k == 2) ? 0 : 1 + $urandom % 6;
			n2 = 2 + $urandom % 5;
			val <= 10'($urandom);
			rc_run <= k[0];
			apb(`CVG_OFF_PRE, 32'(n1), 1);
			apb(`CVG_OFF_ACQ, 32'(n2), 1);
			apb(`CVG_OFF_GRD, 32'he0, 1);
			apb(`CVG_OFF_CTRL, 32'h3 | (k[0] << 4), 1);
			run_conv();
			chk_dur(np, n1, k[0]);
			chk_dur(na, n2, k[0]);
			for (j = 0; j < 2; j++) begin
				apb(`CVG_OFF_CTRL, 32'h1 | (j << 5), 1);
				apb(`CVG_OFF_RESH, 0, 0);
				chk(r, fh(val, j[0]));
				apb(`CVG_OFF_RESL, 0, 0);
				chk(r, fl(val, j[0]));
			end
			apb(`CVG_OFF_RAW, 0, 0);
			chk(r, {22'h0, val});
		end
		rc_run <= 1'b0;
		apb(`CVG_OFF_PRE, 32'h5, 1);
		apb(`CVG_OFF_CTRL, 32'hf, 1);
		r = 0;
		for (i = 0; i < 200 && r[2:0] !== 3'h5; i++)
			apb(`CVG_OFF_STAT, 0, 0);
		if (i == 200)
			timeout();
		repeat (2) @(posedge clk);
		chk({ga, gb}, 0);
		apb(`CVG_OFF_GRD, 0, 0);
		chk(r, 32'he0);
		apb(`CVG_OFF_CTRL, 32'h0, 1);
		// The sequencer sees the cleared enable one edge late, and the stage output lags it once more.
		repeat (3) @(posedge clk);
		chk({st, gao, gbo}, 0);
		end_of_test();
	end
endmodule

// file: verilog/cvg_map.vh
`ifndef CVG_MAP_VH
`define CVG_MAP_VH
`define CVG_OFF_PRE      12'h000
`define CVG_OFF_ACQ      12'h004
`define CVG_OFF_GRD      12'h008
`define CVG_OFF_CAP      12'h00c
`define CVG_OFF_RESH     12'h010
`define CVG_OFF_RESL     12'h014
`define CVG_OFF_CTRL     12'h018
`define CVG_OFF_STAT     12'h01c
`define CVG_OFF_RAW      12'h020
`define CVG_GRD_B_BIT    7
`define CVG_GRD_A_BIT    6
`define CVG_GRD_POL_BIT  5
`define CVG_CTRL_ON_BIT  0
`define CVG_CTRL_GO_BIT  1
`define CVG_CTRL_DS_BIT  2
`define CVG_CTRL_INV_BIT 3
`define CVG_CTRL_RC_BIT  4
`define CVG_CTRL_FM_BIT  5
`define CVG_RST_BYTE     8'h00
`define CVG_INSTR_DIV    2'h3
`define CVG_CONV_CYCLES  4'ha
`define CVG_CAP_STEP_PF  5'h04
`endif

// file: verilog/cvg_result_fmt.v
`timescale 1ns/1ns
module cvg_result_fmt (
	// Raw result and format.
	input  wire [9:0] raw_i,
	input  wire       right_i,
	// Formatted bytes.
	output wire [7:0] high_o,
	output wire [7:0] low_o
);
	// Padding bits are forced to zero when the result is formatted.
	assign high_o = right_i ? {6'h00, raw_i[9:8]} : raw_i[9:2];
	assign low_o  = right_i ? raw_i[7:0] : {raw_i[1:0], 6'h00};
endmodule

// file: verilog/cvg_timing_guard.v
// Functional notes
// - A 7-bit pre-charge count N gives N instruction cycles of pre-charge, and zero removes the stage.
// - A 7-bit acquisition count N gives N instruction cycles of acquisition, and zero removes the stage.
// - With the RC clock selected both stage durations count RC clock ticks instead.
// - The guard B enable routes the guard signal to the guard B pin; software also sets the pin as output.
// - The guard A enable routes the guard signal to the guard A pin; software also sets the pin as output.
// - The start level bit sets the guard level during pre-charge, one high and zero low.
// - With double sample and invert both on, the second conversion uses the inverted start level.
// - Enabled guard outputs are driven the whole time the converter is on.
// - Guard A flips to the opposite level when acquisition begins.
// - The 3-bit extra capacitor code selects 4 pF steps up to 28 pF, zero disabling it.
// - Left-justified, result bits nine to two fill the high byte.
// - Left-justified, result bits one and zero fill the top of the low byte, the rest zero.
// - Right-justified, result bits nine and eight sit at the bottom of the high byte, the rest zero.
// - The format bit picks right-justified when one and left-justified when zero.
// - Right-justified, result bits seven to zero fill the low byte.
// - Unimplemented register bits read as zero and ignore writes.
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`include "cvg_map.vh"
module cvg_timing_guard (
	// Clock and reset.
	input  wire        sys_clk_i,
	input  wire        rst_b_i,
	// APB slave.
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [11:0] paddr_i,
	input  wire [31:0] pwdata_i,
	output reg  [31:0] prdata_o,
	output reg         pready_o,
	output reg         pslverr_o,
	// Converter side.
	input  wire        rc_clk_pin_i,
	input  wire [9:0]  conv_result_i,
	// Guard ring pins.
	output reg         guard_a_pin_o,
	output reg         guard_a_pin_oe_o,
	output reg         guard_b_pin_o,
	output reg         guard_b_pin_oe_o,
	// Extra capacitor and stage status.
	output reg  [7:0]  extra_cap_onehot_o,
	output reg  [4:0]  extra_cap_pf_o,
	output reg  [1:0]  stage_o
);
	localparam ST_IDLE = 2'h0;
	localparam ST_PRE  = 2'h1;
	localparam ST_ACQ  = 2'h2;
	localparam ST_CONV = 2'h3;

	reg [6:0] precharge_cycles;
	reg [6:0] acquire_cycles;
	reg       guard_b_out_en;
	reg       guard_a_out_en;
	reg       guard_start_level;
	reg [2:0] extra_cap_code;
	reg       converter_on;
	reg       go_busy;
	reg       double_sample_en;
	reg       second_sample_invert_en;
	reg       dedicated_rc_clock;
	reg       result_justify_sel;
	reg [9:0] conversion_result;
	reg [1:0] state;
	reg [6:0] count;
	reg       second;
	reg [1:0] div_cnt;
	reg [2:0] rc_sync;
	reg       rc_level;
	reg       guard_level;
	wire      instr_tick;
	wire      rc_tick;
	wire      tick;
	wire      wr_en;
	wire      rd_en;
	wire      conv_done;
	wire [7:0] fmt_high;
	wire [7:0] fmt_low;
	reg [31:0] next_rdata;
	reg        next_err;

	// Byte reads always return a full word with unused bits at zero.
	function [31:0] zext8;
		input [7:0] b;
		zext8 = {24'h000000, b};
	endfunction

	cvg_result_fmt u_fmt (
		.raw_i   (conversion_result),
		.right_i (result_justify_sel),
		.high_o  (fmt_high),
		.low_o   (fmt_low)
	);

	// Instruction cycle is four system clocks; a free divider gives its enable.
	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			div_cnt <= 2'h0;
		end else begin
			div_cnt <= div_cnt + 2'h1;
		end
	end
	assign instr_tick = (div_cnt == `CVG_INSTR_DIV);

	// The RC clock arrives on a pin, so it is synchronised and edge-counted.
	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rc_sync  <= 3'h0;
			rc_level <= 1'b0;
		end else begin
			rc_sync <= {rc_sync[1:0], rc_clk_pin_i};
			if (rc_sync[1] == rc_sync[2]) begin
				rc_level <= rc_sync[2];
			end
		end
	end
	assign rc_tick = (rc_sync[1] == rc_sync[2]) && rc_sync[2] && !rc_level;
	assign tick    = dedicated_rc_clock ? rc_tick : instr_tick;

	assign wr_en = psel_i && penable_i && pwrite_i;
	assign rd_en = psel_i && !penable_i && !pwrite_i;
	assign conv_done = (state == ST_CONV) && tick && (count == 7'h01);

	// Register writes; only implemented bits are stored.
	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			precharge_cycles        <= 7'h00;
			acquire_cycles          <= 7'h00;
			guard_b_out_en          <= 1'b0;
			guard_a_out_en          <= 1'b0;
			guard_start_level       <= 1'b0;
			extra_cap_code          <= 3'h0;
			converter_on            <= 1'b0;
			double_sample_en        <= 1'b0;
			second_sample_invert_en <= 1'b0;
			dedicated_rc_clock      <= 1'b0;
			result_justify_sel      <= 1'b0;
		end else if (wr_en) begin
			if (paddr_i == `CVG_OFF_PRE) begin
				precharge_cycles <= pwdata_i[6:0];
			end else if (paddr_i == `CVG_OFF_ACQ) begin
				acquire_cycles <= pwdata_i[6:0];
			end else if (paddr_i == `CVG_OFF_GRD) begin
				guard_b_out_en    <= pwdata_i[`CVG_GRD_B_BIT];
				guard_a_out_en    <= pwdata_i[`CVG_GRD_A_BIT];
				guard_start_level <= pwdata_i[`CVG_GRD_POL_BIT];
			end else if (paddr_i == `CVG_OFF_CAP) begin
				extra_cap_code <= pwdata_i[2:0];
			end else if (paddr_i == `CVG_OFF_CTRL) begin
				converter_on            <= pwdata_i[`CVG_CTRL_ON_BIT];
				double_sample_en        <= pwdata_i[`CVG_CTRL_DS_BIT];
				second_sample_invert_en <= pwdata_i[`CVG_CTRL_INV_BIT];
				dedicated_rc_clock      <= pwdata_i[`CVG_CTRL_RC_BIT];
				result_justify_sel      <= pwdata_i[`CVG_CTRL_FM_BIT];
			end
		end
	end

	// Sequencer: pre-charge, acquisition, then a fixed conversion span.
	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state   <= ST_IDLE;
			count   <= 7'h00;
			second  <= 1'b0;
			go_busy <= 1'b0;
		end else if (!converter_on) begin
			state   <= ST_IDLE;
			second  <= 1'b0;
			go_busy <= 1'b0;
		end else begin
			if (wr_en && paddr_i == `CVG_OFF_CTRL && pwdata_i[`CVG_CTRL_GO_BIT] && state == ST_IDLE) begin
				go_busy <= 1'b1;
				second  <= 1'b0;
				// Zero durations fall straight through to the next stage.
				if (precharge_cycles != 7'h00) begin
					state <= ST_PRE;
					count <= precharge_cycles;
				end else if (acquire_cycles != 7'h00) begin
					state <= ST_ACQ;
					count <= acquire_cycles;
				end else begin
					state <= ST_CONV;
					count <= {3'h0, `CVG_CONV_CYCLES};
				end
			end else if (tick && state != ST_IDLE) begin
				if (count != 7'h01) begin
					count <= count - 7'h01;
				end else if (state == ST_PRE) begin
					if (acquire_cycles != 7'h00) begin
						state <= ST_ACQ;
						count <= acquire_cycles;
					end else begin
						state <= ST_CONV;
						count <= {3'h0, `CVG_CONV_CYCLES};
					end
				end else if (state == ST_ACQ) begin
					state <= ST_CONV;
					count <= {3'h0, `CVG_CONV_CYCLES};
				end else if (double_sample_en && !second) begin
					second <= 1'b1;
					if (precharge_cycles != 7'h00) begin
						state <= ST_PRE;
						count <= precharge_cycles;
					end else if (acquire_cycles != 7'h00) begin
						state <= ST_ACQ;
						count <= acquire_cycles;
					end else begin
						count <= {3'h0, `CVG_CONV_CYCLES};
					end
				end else begin
					state   <= ST_IDLE;
					go_busy <= 1'b0;
				end
			end
		end
	end

	// Result capture at the end of each conversion span.
	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			conversion_result <= 10'h000;
		end else if (conv_done) begin
			conversion_result <= conv_result_i;
		end
	end

	// Guard level: start level in pre-charge (inverted on second sample when invert is on); only the guard A pin flips it on acquisition.
	always @* begin
		guard_level = guard_start_level ^ (second && double_sample_en && second_sample_invert_en);
	end

	// Guard pins; only guard A flips during acquisition, and they hold while the converter is on.
	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			guard_a_pin_o    <= 1'b0;
			guard_a_pin_oe_o <= 1'b0;
			guard_b_pin_o    <= 1'b0;
			guard_b_pin_oe_o <= 1'b0;
		end else begin
			guard_a_pin_oe_o <= converter_on && guard_a_out_en;
			guard_b_pin_oe_o <= converter_on && guard_b_out_en;
			guard_a_pin_o    <= guard_level ^ (state == ST_ACQ);
			guard_b_pin_o    <= guard_level;
		end
	end

	// Capacitor decode and status outputs.
	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			extra_cap_onehot_o <= 8'h00;
			extra_cap_pf_o     <= 5'h00;
			stage_o            <= 2'h0;
		end else begin
			extra_cap_onehot_o <= (extra_cap_code == 3'h0) ? 8'h00 : (8'h01 << extra_cap_code);
			extra_cap_pf_o     <= extra_cap_code * `CVG_CAP_STEP_PF;
			stage_o            <= state;
		end
	end

	// Read mux; unmapped addresses answer with an error and zero data.
	always @* begin
		next_rdata = 32'h00000000;
		next_err   = 1'b0;
		if (paddr_i == `CVG_OFF_PRE) begin
			next_rdata = zext8({1'b0, precharge_cycles});
		end else if (paddr_i == `CVG_OFF_ACQ) begin
			next_rdata = zext8({1'b0, acquire_cycles});
		end else if (paddr_i == `CVG_OFF_GRD) begin
			next_rdata = zext8({guard_b_out_en, guard_a_out_en, guard_start_level, 5'h00});
		end else if (paddr_i == `CVG_OFF_CAP) begin
			next_rdata = zext8({5'h00, extra_cap_code});
		end else if (paddr_i == `CVG_OFF_RESH) begin
			next_rdata = zext8(fmt_high);
		end else if (paddr_i == `CVG_OFF_RESL) begin
			next_rdata = zext8(fmt_low);
		end else if (paddr_i == `CVG_OFF_CTRL) begin
			next_rdata = zext8({2'h0, result_justify_sel, dedicated_rc_clock, second_sample_invert_en,
				double_sample_en, go_busy, converter_on});
		end else if (paddr_i == `CVG_OFF_STAT) begin
			next_rdata = zext8({5'h00, second, state});
		end else if (paddr_i == `CVG_OFF_RAW) begin
			next_rdata = {22'h000000, conversion_result};
		end else begin
			next_err = 1'b1;
		end
	end

	// No wait states: data and ready are registered in the setup cycle.
	always @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prdata_o  <= 32'h00000000;
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o  <= psel_i && !penable_i;
			pslverr_o <= psel_i && !penable_i && next_err;
			if (rd_en) begin
				prdata_o <= next_rdata;
			end
		end
	end
endmodule
